// file: hw/smbus_register_slave_protocol.sv
// Two-wire serial register slave: link sequencer, write FIFO and register port.
//
// Notes on behaviour
// - Byte write, byte read, block write, block read.
// - Block bytes ascend from zero, MSB first.
// - Stop after any whole byte is accepted.
// - Answer only address D2, else stay silent.
// - Command bit 7 picks byte or block.
// - Command bits 6:0 index single byte access.
// - Start, address, direction, then device acknowledges.
// - Device acknowledges the command code.
// - Block write: count, data bytes, all acknowledged.
// - Block read: restart, acknowledge, count, data.
// - Byte write: one data byte, acknowledged.
// - Byte read: restart, acknowledge, one byte.
// - Data pin drives only open-drain when answering.
// - Everything returns to defaults at power-up.
`timescale 1ns/10ps
`default_nettype none
module smbus_register_slave_protocol
    import smbus_slave_pkg::*;
#(
    parameter logic [7:0] BLOCK_COUNT = DEF_BLOCK_COUNT,
    parameter int FIFO_DEPTH = DEF_FIFO_DEPTH
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic link_clk_i,
    input wire logic serial_clock_i,
    output logic serial_clock_o,
    output logic serial_clock_oe_o,
    input wire logic serial_data_line_i,
    output logic serial_data_line_o,
    output logic serial_data_line_oe_o,
    output logic reg_wr_o,
    output logic [IDX_W-1:0] reg_wr_idx_o,
    output logic [7:0] reg_wdata_o,
    input wire logic reg_wr_ready_i,
    output logic reg_rd_o,
    output logic [IDX_W-1:0] reg_rd_idx_o,
    input wire logic [7:0] reg_rdata_i
);

    // ------------------------------------------------------------
    // Link-domain reset release
    // ------------------------------------------------------------
    logic [1:0] link_rst_sync;
    logic link_rst_b;

    always_ff @(posedge link_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            link_rst_sync <= LINK_RST_SYNC_RST;
        end else begin
            link_rst_sync <= {link_rst_sync[0], 1'b1};
        end
    end

    assign link_rst_b = link_rst_sync[1];

    // ------------------------------------------------------------
    // State records and write FIFO
    // ------------------------------------------------------------
    link_regs_t lk;
    link_regs_t next_lk;
    sys_regs_t sy;
    sys_regs_t next_sy;

    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [WR_ENTRY_W-1:0] fifo_out_data;

    // Writes are queued so that a slow register file only stretches the
    // link on a burst, not on every byte.
    assign fifo_in_valid = (lk.state == s_push);

    async_word_fifo #(
        .WIDTH(WR_ENTRY_W),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_fifo (
        .wr_clk_i(link_clk_i),
        .wr_rst_b_i(link_rst_b),
        .wr_valid_i(fifo_in_valid),
        .wr_ready_o(fifo_in_ready),
        .wr_data_i({lk.idx, lk.shreg}),
        .rd_clk_i(mclk_i),
        .rd_rst_b_i(rst_b_i),
        .rd_valid_o(fifo_out_valid),
        .rd_ready_i(reg_wr_ready_i),
        .rd_data_o(fifo_out_data)
    );

    // ------------------------------------------------------------
    // Link sequencer
    // ------------------------------------------------------------
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic rd_done;

    always_comb begin
        scl_rise = lk.scl2 && !lk.scl3;
        scl_fall = !lk.scl2 && lk.scl3;
        bus_start = lk.scl2 && lk.scl3 && lk.sda3 && !lk.sda2;
        bus_stop = lk.scl2 && lk.scl3 && !lk.sda3 && lk.sda2;
        rd_done = (lk.ack2 != lk.ack_seen);
    end

    always_comb begin
        next_lk = lk;
        next_lk.scl1 = serial_clock_i;
        next_lk.scl2 = lk.scl1;
        next_lk.scl3 = lk.scl2;
        next_lk.sda1 = serial_data_line_i;
        next_lk.sda2 = lk.sda1;
        next_lk.sda3 = lk.sda2;
        next_lk.ack1 = sy.ack_tgl;
        next_lk.ack2 = lk.ack1;
        if (rd_done) begin
            next_lk.ack_seen = lk.ack2;
            next_lk.rd_pend = 1'b0;
        end
        if (bus_start) begin
            next_lk.state = s_addr;
            next_lk.bits = '0;
            next_lk.sda_oe = 1'b0;
            next_lk.scl_oe = 1'b0;
            if (lk.state != s_rx) begin
                next_lk.got_cmd = 1'b0;
            end
        end else if (bus_stop) begin
            next_lk.state = s_idle;
            next_lk.sda_oe = 1'b0;
            next_lk.scl_oe = 1'b0;
        end else begin
            case (lk.state)
                s_idle: begin
                    next_lk.sda_oe = 1'b0;
                end
                s_addr: begin
                    if (scl_rise) begin
                        next_lk.shreg = {lk.shreg[6:0], lk.sda2};
                        next_lk.bits = lk.bits + 4'h1;
                    end else if (scl_fall && lk.bits == BITS_PER_BYTE) begin
                        if (lk.shreg[7:1] == DEV_ADDR[7:1]) begin
                            next_lk.rnw = lk.shreg[0];
                            next_lk.addr_ack = 1'b1;
                            next_lk.state = s_ack;
                            next_lk.sda_oe = 1'b1;
                        end else begin
                            next_lk.state = s_ignore;
                        end
                    end
                end
                s_rx: begin
                    if (scl_rise) begin
                        next_lk.shreg = {lk.shreg[6:0], lk.sda2};
                        next_lk.bits = lk.bits + 4'h1;
                    end else if (scl_fall && lk.bits == BITS_PER_BYTE) begin
                        next_lk.bits = '0;
                        if (!lk.got_cmd) begin
                            next_lk.got_cmd = 1'b1;
                            next_lk.got_first = 1'b0;
                            next_lk.byte_op = lk.shreg[CMD_SEL_BIT];
                            next_lk.idx = lk.shreg[CMD_SEL_BIT] ? lk.shreg[IDX_W-1:0] : '0;
                            next_lk.state = s_ack;
                            next_lk.sda_oe = 1'b1;
                        end else if (!lk.byte_op && !lk.got_first) begin
                            next_lk.got_first = 1'b1;
                            next_lk.state = s_ack;
                            next_lk.sda_oe = 1'b1;
                        end else if (lk.byte_op && lk.got_first) begin
                            next_lk.state = s_ignore;
                        end else begin
                            next_lk.got_first = 1'b1;
                            next_lk.state = s_push;
                            next_lk.sda_oe = 1'b1;
                            next_lk.scl_oe = 1'b1;
                        end
                    end
                end
                s_push: begin
                    // Clock is held low until the FIFO takes the byte.
                    if (fifo_in_ready) begin
                        if (!lk.byte_op) begin
                            next_lk.idx = lk.idx + 7'h01;
                        end
                        next_lk.state = s_ack;
                        next_lk.scl_oe = 1'b0;
                    end
                end
                s_ack: begin
                    if (scl_fall) begin
                        next_lk.sda_oe = 1'b0;
                        next_lk.addr_ack = 1'b0;
                        next_lk.bits = '0;
                        if (lk.addr_ack && lk.rnw) begin
                            next_lk.state = s_load;
                            next_lk.scl_oe = 1'b1;
                        end else begin
                            next_lk.state = s_rx;
                        end
                    end
                end
                s_load: begin
                    if (!lk.byte_op && !lk.got_first) begin
                        next_lk.got_first = 1'b1;
                        next_lk.shreg = BLOCK_COUNT;
                        next_lk.sda_oe = !BLOCK_COUNT[7];
                        next_lk.scl_oe = 1'b0;
                        next_lk.bits = '0;
                        next_lk.state = s_tx;
                    end else if (rd_done) begin
                        next_lk.got_first = 1'b1;
                        next_lk.shreg = sy.rd_hold;
                        next_lk.sda_oe = !sy.rd_hold[7];
                        next_lk.scl_oe = 1'b0;
                        next_lk.bits = '0;
                        next_lk.idx = lk.idx + 7'h01;
                        next_lk.state = s_tx;
                    end else if (!lk.rd_pend) begin
                        next_lk.rd_pend = 1'b1;
                        next_lk.rd_req = !lk.rd_req;
                    end
                end
                s_tx: begin
                    if (scl_fall) begin
                        next_lk.bits = lk.bits + 4'h1;
                        if (lk.bits == LAST_TX_BIT) begin
                            next_lk.sda_oe = 1'b0;
                            next_lk.state = s_mack;
                        end else begin
                            next_lk.shreg = {lk.shreg[6:0], 1'b0};
                            next_lk.sda_oe = !lk.shreg[6];
                        end
                    end
                end
                s_mack: begin
                    if (scl_rise && lk.sda2) begin
                        next_lk.state = s_ignore;
                    end else if (scl_fall) begin
                        next_lk.state = s_load;
                        next_lk.scl_oe = 1'b1;
                    end
                end
                s_ignore: begin
                    next_lk.sda_oe = 1'b0;
                    next_lk.scl_oe = 1'b0;
                end
                default: begin
                    next_lk.state = s_idle;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk_i or negedge link_rst_b) begin
        if (!link_rst_b) begin
            lk <= LINK_RST;
        end else begin
            lk <= next_lk;
        end
    end

    // ------------------------------------------------------------
    // Register port on the system clock
    // ------------------------------------------------------------
    // A read is served only once queued writes have drained, so a byte
    // written and read back in one session returns the new value.
    always_comb begin
        next_sy = sy;
        next_sy.req1 = lk.rd_req;
        next_sy.req2 = sy.req1;
        next_sy.wr = fifo_out_valid && reg_wr_ready_i;
        next_sy.rd = 1'b0;
        if (fifo_out_valid && reg_wr_ready_i) begin
            next_sy.wr_idx = fifo_out_data[WR_ENTRY_W-1:8];
            next_sy.wdata = fifo_out_data[7:0];
        end
        // The register file answers in the cycle after the strobe, so the
        // capture waits until the strobe has dropped.
        if (sy.rd_wait && !sy.rd) begin
            next_sy.rd_wait = 1'b0;
            next_sy.rd_hold = reg_rdata_i;
            next_sy.ack_tgl = !sy.ack_tgl;
        end else if (sy.req2 != sy.req_seen && !fifo_out_valid && !sy.wr) begin
            next_sy.rd = 1'b1;
            next_sy.rd_idx = lk.idx;
            next_sy.req_seen = sy.req2;
            next_sy.rd_wait = 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sy <= SYS_RST;
        end else begin
            sy <= next_sy;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign serial_clock_o = lk.drive_lvl;
    assign serial_clock_oe_o = lk.scl_oe;
    assign serial_data_line_o = lk.drive_lvl;
    assign serial_data_line_oe_o = lk.sda_oe;
    assign reg_wr_o = sy.wr;
    assign reg_wr_idx_o = sy.wr_idx;
    assign reg_wdata_o = sy.wdata;
    assign reg_rd_o = sy.rd;
    assign reg_rd_idx_o = sy.rd_idx;

endmodule : smbus_register_slave_protocol
`default_nettype wire

// file: hw/smbus_slave_pkg.sv
// Constants, state encodings and state records for the serial register slave.
package smbus_slave_pkg;

    // ------------------------------------------------------------
    // Bus addressing and command decode
    // ------------------------------------------------------------
    localparam logic [7:0] DEV_ADDR = 8'hD2;
    localparam int CMD_SEL_BIT = 7;
    localparam int IDX_W = 7;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;

    // ------------------------------------------------------------
    // Sizes and defaults
    // ------------------------------------------------------------
    localparam logic [7:0] DEF_BLOCK_COUNT = 8'h08;
    localparam int DEF_FIFO_DEPTH = 4;
    localparam int WR_ENTRY_W = 15;
    localparam logic [1:0] LINK_RST_SYNC_RST = 2'h0;

    // ------------------------------------------------------------
    // Link-side sequencer
    // ------------------------------------------------------------
    typedef enum logic [8:0] {
        s_idle   = 9'h001,
        s_addr   = 9'h002,
        s_rx     = 9'h004,
        s_ack    = 9'h008,
        s_push   = 9'h010,
        s_load   = 9'h020,
        s_tx     = 9'h040,
        s_mack   = 9'h080,
        s_ignore = 9'h100
    } link_state_t;

    typedef struct packed {
        link_state_t state;
        logic scl1;
        logic scl2;
        logic scl3;
        logic sda1;
        logic sda2;
        logic sda3;
        logic [3:0] bits;
        logic [7:0] shreg;
        logic rnw;
        logic byte_op;
        logic got_cmd;
        logic got_first;
        logic addr_ack;
        logic [IDX_W-1:0] idx;
        logic rd_pend;
        logic rd_req;
        logic ack1;
        logic ack2;
        logic ack_seen;
        logic sda_oe;
        logic scl_oe;
        logic drive_lvl;
    } link_regs_t;

    localparam link_regs_t LINK_RST = '{state: s_idle, scl1: 1'b1, scl2: 1'b1,
        scl3: 1'b1, sda1: 1'b1, sda2: 1'b1, sda3: 1'b1, default: '0};

    // ------------------------------------------------------------
    // System-side register port
    // ------------------------------------------------------------
    typedef struct packed {
        logic req1;
        logic req2;
        logic req_seen;
        logic rd_wait;
        logic [7:0] rd_hold;
        logic ack_tgl;
        logic wr;
        logic [IDX_W-1:0] wr_idx;
        logic [7:0] wdata;
        logic rd;
        logic [IDX_W-1:0] rd_idx;
    } sys_regs_t;

    localparam sys_regs_t SYS_RST = '0;

endpackage : smbus_slave_pkg

// file: hw/async_word_fifo.sv
// Dual-clock word FIFO with gray-coded pointers and valid/ready on both sides.
`timescale 1ns/10ps
`default_nettype none
module async_word_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 4
) (
    input wire logic wr_clk_i,
    input wire logic wr_rst_b_i,
    input wire logic wr_valid_i,
    output logic wr_ready_o,
    input wire logic [WIDTH-1:0] wr_data_i,
    input wire logic rd_clk_i,
    input wire logic rd_rst_b_i,
    output logic rd_valid_o,
    input wire logic rd_ready_i,
    output logic [WIDTH-1:0] rd_data_o
);
    // DEPTH must be a power of two and at least four.
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] bin;
        logic [AW:0] gray;
        logic [AW:0] q1;
        logic [AW:0] q2;
    } ptr_regs_t;

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction : to_gray

    logic [WIDTH-1:0] mem [DEPTH];
    ptr_regs_t w;
    ptr_regs_t next_w;
    ptr_regs_t r;
    ptr_regs_t next_r;

    // ------------------------------------------------------------
    // Write side
    // ------------------------------------------------------------
    assign wr_ready_o = (w.gray != {~w.q2[AW:AW-1], w.q2[AW-2:0]});

    always_comb begin
        next_w = w;
        next_w.q1 = r.gray;
        next_w.q2 = w.q1;
        if (wr_valid_i && wr_ready_o) begin
            next_w.bin = w.bin + 1'b1;
            next_w.gray = to_gray(next_w.bin);
        end
    end

    always_ff @(posedge wr_clk_i or negedge wr_rst_b_i) begin
        if (!wr_rst_b_i) begin
            w <= '0;
        end else begin
            w <= next_w;
        end
    end

    always_ff @(posedge wr_clk_i) begin
        if (wr_valid_i && wr_ready_o) begin
            mem[w.bin[AW-1:0]] <= wr_data_i;
        end
    end

    // ------------------------------------------------------------
    // Read side
    // ------------------------------------------------------------
    assign rd_valid_o = (r.gray != r.q2);
    assign rd_data_o = mem[r.bin[AW-1:0]];

    always_comb begin
        next_r = r;
        next_r.q1 = w.gray;
        next_r.q2 = r.q1;
        if (rd_valid_o && rd_ready_i) begin
            next_r.bin = r.bin + 1'b1;
            next_r.gray = to_gray(next_r.bin);
        end
    end

    always_ff @(posedge rd_clk_i or negedge rd_rst_b_i) begin
        if (!rd_rst_b_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

endmodule : async_word_fifo
`default_nettype wire

// file: test/smbus_slave_sva.sv
// Concurrent checks on the port behaviour of the serial register slave.
`timescale 1ns/10ps
`default_nettype none
module smbus_slave_sva
    import smbus_slave_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic link_clk_i,
    input wire logic serial_clock_i,
    input wire logic serial_clock_o,
    input wire logic serial_clock_oe_o,
    input wire logic serial_data_line_i,
    input wire logic serial_data_line_o,
    input wire logic serial_data_line_oe_o,
    input wire logic reg_wr_o,
    input wire logic [IDX_W-1:0] reg_wr_idx_o,
    input wire logic [7:0] reg_wdata_o,
    input wire logic reg_wr_ready_i,
    input wire logic reg_rd_o,
    input wire logic [IDX_W-1:0] reg_rd_idx_o,
    input wire logic [7:0] reg_rdata_i
);
    // ------------------------------------------------------------
    // Sequences and properties
    // ------------------------------------------------------------
    sequence rd_pulse_s;
        reg_rd_o ##1 !reg_rd_o;
    endsequence
    sequence bit_hold_s;
        serial_data_line_oe_o [*2];
    endsequence
    rd_single_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        reg_rd_o |-> rd_pulse_s) else $error("read strobe not a single cycle");
    wr_ready_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        reg_wr_o |-> $past(reg_wr_ready_i)) else $error("write while port not ready");
    rd_excl_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        reg_rd_o |-> !reg_wr_o) else $error("read and write strobes together");
    rd_idx_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        !reg_rd_o |-> $stable(reg_rd_idx_o)) else $error("read index moved");
    wr_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        !reg_wr_o |-> $stable({reg_wr_idx_o, reg_wdata_o})) else $error("write data moved");
    pin_zero_a: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
        !serial_data_line_o && !serial_clock_o) else $error("pin driven high");
    // The data drive may only move while the clock wire is low.
    oe_low_a: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
        $changed(serial_data_line_oe_o) |-> !$past(serial_clock_i)) else $error("data moved");
    oe_stands_a: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
        $rose(serial_clock_i) && serial_data_line_oe_o |-> bit_hold_s)
        else $error("data drive dropped in high phase");
    stretch_low_a: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
        $rose(serial_clock_oe_o) |-> !$past(serial_clock_i)) else $error("stretch while high");
endmodule : smbus_slave_sva
bind smbus_register_slave_protocol smbus_slave_sva sva_i (.mclk_i, .rst_b_i, .link_clk_i,
    .serial_clock_i, .serial_clock_o, .serial_clock_oe_o, .serial_data_line_i,
    .serial_data_line_o, .serial_data_line_oe_o, .reg_wr_o, .reg_wr_idx_o, .reg_wdata_o,
    .reg_wr_ready_i, .reg_rd_o, .reg_rd_idx_o, .reg_rdata_i);
`default_nettype wire

// file: test/smbus_host_model.sv
// Behavioural bus master that drives the two-wire link on the link clock.
`timescale 1ns/10ps
`default_nettype none
module smbus_host_model (
    input wire logic clk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_low_o,
    output logic sda_low_o
);
    // ------------------------------------------------------------
    // Bit timing
    // ------------------------------------------------------------
    initial begin
        scl_low_o = 1'b0;
        sda_low_o = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(posedge clk_i);
    endtask : w
    // The slave may hold the clock low, so a rising edge waits for the wire.
    task automatic rise();
        scl_low_o <= 1'b0;
        w(1);
        while (scl_i !== 1'b1) w(1);
        w(5);
    endtask : rise
    task automatic start();
        w(5);
        sda_low_o <= 1'b0;
        w(5);
        rise();
        sda_low_o <= 1'b1;
        w(5);
        scl_low_o <= 1'b1;
    endtask : start
    task automatic stop();
        w(5);
        sda_low_o <= 1'b1;
        w(5);
        rise();
        sda_low_o <= 1'b0;
        w(10);
    endtask : stop
    task automatic bitx(input logic b, output logic r);
        w(5);
        sda_low_o <= ~b;
        w(5);
        rise();
        @(negedge clk_i);
        r = sda_i;
        w(5);
        scl_low_o <= 1'b1;
    endtask : bitx
    task automatic wbyte(input logic [7:0] v, output logic nak);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(v[i], r);
        bitx(1'b1, nak);
    endtask : wbyte
    task automatic rbyte(input logic last, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(1'b1, v[i]);
        bitx(last, r);
    endtask : rbyte
endmodule : smbus_host_model
`default_nettype wire

// file: test/tb.sv
// Self-checking bench for the serial register slave with a host and a register file.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import smbus_slave_pkg::*;
    // ------------------------------------------------------------
    // Clocks, pins and register file
    // ------------------------------------------------------------
    logic mclk = 1'b0;
    logic lclk = 1'b0;
    logic rst_b = 1'b0;
    logic rdy = 1'b1;
    logic [7:0] rdata = 8'h00;
    logic [7:0] mem [128];
    logic [7:0] wr_n = 8'h00;
    int bad_count = 0;
    int n_compared = 0;
    wire logic scl_low, sda_low, scl_oe, sda_oe, wr, rd;
    wire logic [IDX_W-1:0] wr_idx, rd_idx;
    wire logic [7:0] wdata;
    // Both pins are pulled up and pulled low by whichever party drives.
    wire logic scl = ~(scl_oe | scl_low);
    wire logic sda = ~(sda_oe | sda_low);
    always #5 mclk = ~mclk;
    always #6 lclk = ~lclk;
    smbus_register_slave_protocol #(.BLOCK_COUNT(8'h03), .FIFO_DEPTH(4)) uut (.mclk_i(mclk),
        .rst_b_i(rst_b), .link_clk_i(lclk), .serial_clock_i(scl), .serial_clock_o(),
        .serial_clock_oe_o(scl_oe), .serial_data_line_i(sda), .serial_data_line_o(),
        .serial_data_line_oe_o(sda_oe), .reg_wr_o(wr), .reg_wr_idx_o(wr_idx),
        .reg_wdata_o(wdata), .reg_wr_ready_i(rdy), .reg_rd_o(rd), .reg_rd_idx_o(rd_idx),
        .reg_rdata_i(rdata));
    smbus_host_model host (.clk_i(lclk), .scl_i(scl), .sda_i(sda), .scl_low_o(scl_low),
        .sda_low_o(sda_low));
    always @(posedge mclk) begin
        if (wr) begin
            mem[wr_idx] <= wdata;
            wr_n <= wr_n + 8'h01;
        end
        if (rd) rdata <= mem[rd_idx];
    end
    function automatic logic [7:0] init_val(input int i);
        return 8'(i) ^ 8'hC3;
    endfunction : init_val
    // ------------------------------------------------------------
    // Shared steps
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic open_cmd(input logic [7:0] cmd);
        logic n;
        host.start();
        host.wbyte(DEV_ADDR, n);
        chk({7'h00, n}, 8'h00);
        host.wbyte(cmd, n);
        chk({7'h00, n}, 8'h00);
    endtask : open_cmd
    task automatic read_open();
        logic n;
        host.start();
        host.wbyte(DEV_ADDR | 8'h01, n);
        chk({7'h00, n}, 8'h00);
    endtask : read_open
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk({4'h0, scl_oe, sda_oe, wr, rd}, 8'h00);
    endtask : t_reset
    task automatic t_byte_write();
        logic n;
        open_cmd(8'hC5);
        host.wbyte(8'h3C, n);
        chk({7'h00, n}, 8'h00);
        host.wbyte(8'h99, n);
        chk({7'h00, n}, 8'h01);
        host.stop();
        repeat (20) @(posedge mclk);
        chk(mem[69], 8'h3C);
        chk(mem[70], init_val(70));
    endtask : t_byte_write
    task automatic t_byte_read();
        logic [7:0] v;
        open_cmd(8'hC5);
        read_open();
        host.rbyte(1'b1, v);
        chk(v, 8'h3C);
        host.stop();
    endtask : t_byte_read
    task automatic t_block_write();
        logic n;
        @(posedge mclk);
        rdy <= 1'b0;
        fork
            begin
                open_cmd(8'h00);
                host.wbyte(8'h06, n);
                chk({7'h00, n}, 8'h00);
                for (int i = 0; i < 6; i++) begin
                    host.wbyte(8'h10 + 8'(i), n);
                    chk({7'h00, n}, 8'h00);
                end
                host.stop();
            end
            begin
                repeat (4000) @(posedge mclk);
                chk({7'h00, scl_oe}, 8'h01);
                chk(wr_n, 8'h01);
                rdy <= 1'b1;
            end
        join
        repeat (20) @(posedge mclk);
        for (int i = 0; i < 6; i++) chk(mem[i], 8'h10 + 8'(i));
        chk(mem[6], init_val(6));
    endtask : t_block_write
    task automatic t_block_read();
        logic [7:0] v;
        open_cmd(8'h00);
        read_open();
        host.rbyte(1'b0, v);
        chk(v, 8'h03);
        for (int i = 0; i < 3; i++) begin
            host.rbyte(i == 2, v);
            chk(v, 8'h10 + 8'(i));
        end
        host.stop();
    endtask : t_block_read
    task automatic t_foreign();
        logic n;
        logic [7:0] w0;
        w0 = wr_n;
        foreach (mem[k]) if (k < 2) begin
            host.start();
            host.wbyte(k == 0 ? 8'hD6 : 8'h52, n);
            chk({7'h00, n}, 8'h01);
            host.wbyte(8'hC5, n);
            chk({7'h00, n}, 8'h01);
            host.stop();
        end
        repeat (20) @(posedge mclk);
        chk(wr_n, w0);
    endtask : t_foreign
    task automatic final_report();
        if (bad_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    initial begin
        for (int i = 0; i < 128; i++) mem[i] = init_val(i);
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        t_reset();
        repeat (10) @(posedge mclk);
        t_byte_write();
        t_byte_read();
        t_block_write();
        t_block_read();
        t_foreign();
        final_report();
    end
    // The whole run needs about 90 us, so this leaves a wide margin.
    initial begin
        #400000;
        bad_count++;
        final_report();
    end
endmodule : tb
`default_nettype wire
